// file: logic/ccr_defs.svh
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH
// register byte offsets
`define CCR_OFF_WAKE       8'h00
`define CCR_OFF_DRIVE      8'h04
`define CCR_OFF_SLEW       8'h08
`define CCR_OFF_PULLDOWN   8'h0C
`define CCR_OFF_IDTEST     8'h10
// address bits decoded inside the block
`define CCR_ADDR_MSB       7
// wake config fields
`define CCR_WAKE_SRC_MSB   26
`define CCR_WAKE_FILT_BIT  31
// implemented pin bits: 31,30,28,27..20,15..0
`define CCR_PIN_MASK       32'hDFF0FFFF
`define CCR_WAKE_MASK      32'h87FFFFFF
// reset value of all read/write bits
`define CCR_RESET_WORD     32'h00000000
`define CCR_RESET_HALF     16'h0000
// identification codes, values arbitrary
`define CCR_PART_NUMBER    8'h5A
`define CCR_MASK_REV       8'h01
// glitch filter: stable samples required
`define CCR_FILT_LEN       3
// ahb encodings
`define CCR_HTRANS_NONSEQ  2'h2
`define CCR_HTRANS_SEQ     2'h3
`define CCR_HRESP_OKAY     1'h0
`define CCR_HRESP_ERROR    1'h1
// hprot bit 1: privileged access
`define CCR_HPROT_PRIV     1
// factory test half of the shared word
`define CCR_TEST_MSB       15
// wake select groups
`define CCR_WK_GRPA_LSB    0
`define CCR_WK_GRPA_MSB    7
`define CCR_WK_GRPB_LSB    8
`define CCR_WK_GRPB_MSB    15
// wake select bits of single sources
`define CCR_WK_WDOG_A_RST  16
`define CCR_WK_RESET_PIN   17
`define CCR_WK_DEBUG_ON    18
`define CCR_WK_WDOG_A_IRQ  19
`define CCR_WK_I2C         20
`define CCR_WK_WDOG_B_RST  21
`define CCR_WK_WDOG_B_IRQ  22
`define CCR_WK_COMP_ZERO   23
`define CCR_WK_COMP_ONE    24
`define CCR_WK_USB_RESUME  25
`define CCR_WK_VOLT_DET    26
`endif

// file: logic/ccr_pkg.sv
`default_nettype none
package ccr_pkg;
    typedef enum logic [1:0] {
        CCR_IDLE,
        CCR_ERR1,
        CCR_ERR2
    } ccr_state_t;
endpackage : ccr_pkg
`default_nettype wire

// file: logic/ccr_chip_config.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccr_defs.svh"

module ccr_chip_config
    import ccr_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [3:0]  hprot,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [26:0] wake_sources,
    output logic             wake_request,
    output logic      [31:0] drive_reduce_bits,
    output logic      [31:0] slew_limit_bits,
    output logic      [31:0] pulldown_enable_bits,
    output logic      [15:0] test_control
);

    // ************************************************************
    // address phase decode
    // ************************************************************
    logic [31:0] wake_config;
    logic [31:0] drive_reduce_config;
    logic [31:0] slew_limit_config;
    logic [31:0] pulldown_config;
    logic [15:0] factory_test;
    ccr_state_t  state;
    ccr_state_t  next_state;
    logic                   dp_write;
    logic [`CCR_ADDR_MSB:0] dp_addr;

    wire trans_ok  = hsel && hready && (htrans == `CCR_HTRANS_NONSEQ || htrans == `CCR_HTRANS_SEQ);
    wire privilege = hprot[`CCR_HPROT_PRIV];
    wire user_acc  = trans_ok && !privilege;
    wire good_acc  = trans_ok && privilege;
    wire next_dp_write = good_acc && hwrite;
    wire [`CCR_ADDR_MSB:0] addr_lo = haddr[`CCR_ADDR_MSB:0];

    // ************************************************************
    // data phase decode
    // ************************************************************
    wire sel_wake  = dp_write && dp_addr == `CCR_OFF_WAKE;
    wire sel_drive = dp_write && dp_addr == `CCR_OFF_DRIVE;
    wire sel_slew  = dp_write && dp_addr == `CCR_OFF_SLEW;
    wire sel_pd    = dp_write && dp_addr == `CCR_OFF_PULLDOWN;
    wire sel_test  = dp_write && dp_addr == `CCR_OFF_IDTEST;

    // ************************************************************
    // register next values, pending write seen by reads
    // ************************************************************
    wire [31:0] next_wake_config         = sel_wake  ? (hwdata & `CCR_WAKE_MASK) : wake_config;
    wire [31:0] next_drive_reduce_config = sel_drive ? hwdata : drive_reduce_config;
    wire [31:0] next_slew_limit_config   = sel_slew  ? hwdata : slew_limit_config;
    wire [31:0] next_pulldown_config     = sel_pd    ? hwdata : pulldown_config;
    wire [15:0] next_factory_test        = sel_test  ? hwdata[`CCR_TEST_MSB:0] : factory_test;

    // ************************************************************
    // read data select
    // ************************************************************
    wire rd_wake  = addr_lo == `CCR_OFF_WAKE;
    wire rd_drive = addr_lo == `CCR_OFF_DRIVE;
    wire rd_slew  = addr_lo == `CCR_OFF_SLEW;
    wire rd_pd    = addr_lo == `CCR_OFF_PULLDOWN;
    wire rd_id    = addr_lo == `CCR_OFF_IDTEST;

    wire [31:0] rd_mux =
        rd_wake  ? next_wake_config :
        rd_drive ? next_drive_reduce_config :
        rd_slew  ? next_slew_limit_config :
        rd_pd    ? next_pulldown_config :
        rd_id    ? {`CCR_PART_NUMBER, `CCR_MASK_REV, next_factory_test} :
                   `CCR_RESET_WORD;
    wire [31:0] next_hrdata = (good_acc && !hwrite) ? rd_mux : `CCR_RESET_WORD;

    // ************************************************************
    // error response sequencing
    // ************************************************************
    always_comb begin
        case (state)
            CCR_IDLE: next_state = user_acc ? CCR_ERR1 : CCR_IDLE;
            CCR_ERR1: next_state = CCR_ERR2;
            CCR_ERR2: next_state = user_acc ? CCR_ERR1 : CCR_IDLE;
            default:  next_state = CCR_IDLE;
        endcase
    end

    wire next_hreadyout = next_state != CCR_ERR1;
    wire next_hresp     = next_state != CCR_IDLE ? `CCR_HRESP_ERROR : `CCR_HRESP_OKAY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= CCR_IDLE;
            hreadyout <= 1'b1;
            hresp     <= `CCR_HRESP_OKAY;
        end else begin
            state     <= next_state;
            hreadyout <= next_hreadyout;
            hresp     <= next_hresp;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `CCR_RESET_WORD;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= '0;
        end else begin
            dp_write <= next_dp_write;
            dp_addr  <= addr_lo;
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_config <= `CCR_RESET_WORD;
        end else begin
            wake_config <= next_wake_config;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_reduce_config <= `CCR_RESET_WORD;
        end else begin
            drive_reduce_config <= next_drive_reduce_config;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slew_limit_config <= `CCR_RESET_WORD;
        end else begin
            slew_limit_config <= next_slew_limit_config;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulldown_config <= `CCR_RESET_WORD;
        end else begin
            pulldown_config <= next_pulldown_config;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            factory_test <= `CCR_RESET_HALF;
        end else begin
            factory_test <= next_factory_test;
        end
    end

    // ************************************************************
    // pin configuration outputs
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_reduce_bits <= `CCR_RESET_WORD;
        end else begin
            drive_reduce_bits <= drive_reduce_config & `CCR_PIN_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slew_limit_bits <= `CCR_RESET_WORD;
        end else begin
            slew_limit_bits <= slew_limit_config & `CCR_PIN_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulldown_enable_bits <= `CCR_RESET_WORD;
        end else begin
            pulldown_enable_bits <= pulldown_config & `CCR_PIN_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            test_control <= `CCR_RESET_HALF;
        end else begin
            test_control <= factory_test;
        end
    end

    // ************************************************************
    // wake sources: sync, filter, select
    // ************************************************************
    logic [26:0] src_s1;
    logic [26:0] src_s2;
    logic [26:0] src_filt;
    logic [26:0] src_d1;
    logic [26:0] src_d2;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_s1 <= '0;
            src_s2 <= '0;
        end else begin
            src_s1 <= wake_sources;
            src_s2 <= src_s1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_d1 <= '0;
            src_d2 <= '0;
        end else begin
            src_d1 <= src_s2;
            src_d2 <= src_d1;
        end
    end

    // deglitch: output follows once CCR_FILT_LEN samples agree
    wire [`CCR_WAKE_SRC_MSB:0] all_hi    = src_s2 & src_d1 & src_d2;
    wire [`CCR_WAKE_SRC_MSB:0] all_lo    = ~(src_s2 | src_d1 | src_d2);
    wire [`CCR_WAKE_SRC_MSB:0] next_filt = all_hi | (src_filt & ~all_lo);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_filt <= '0;
        end else begin
            src_filt <= next_filt;
        end
    end

    wire         filt_en     = wake_config[`CCR_WAKE_FILT_BIT];
    wire  [26:0] src_sel     = filt_en ? src_filt : src_s2;
    wire  [26:0] src_enabled = src_sel & wake_config[`CCR_WAKE_SRC_MSB:0];

    // ************************************************************
    // wake requests per source
    // ************************************************************
    wire [7:0] wake_grp_a      = src_enabled[`CCR_WK_GRPA_MSB:`CCR_WK_GRPA_LSB];
    wire [7:0] wake_grp_b      = src_enabled[`CCR_WK_GRPB_MSB:`CCR_WK_GRPB_LSB];
    wire       wake_wdog_a_rst = src_enabled[`CCR_WK_WDOG_A_RST];
    wire       wake_reset_pin  = src_enabled[`CCR_WK_RESET_PIN];
    wire       wake_debug_on   = src_enabled[`CCR_WK_DEBUG_ON];
    wire       wake_wdog_a_irq = src_enabled[`CCR_WK_WDOG_A_IRQ];
    wire       wake_i2c        = src_enabled[`CCR_WK_I2C];
    wire       wake_wdog_b_rst = src_enabled[`CCR_WK_WDOG_B_RST];
    wire       wake_wdog_b_irq = src_enabled[`CCR_WK_WDOG_B_IRQ];
    wire       wake_comp_zero  = src_enabled[`CCR_WK_COMP_ZERO];
    wire       wake_comp_one   = src_enabled[`CCR_WK_COMP_ONE];
    wire       wake_usb_resume = src_enabled[`CCR_WK_USB_RESUME];
    wire       wake_volt_det   = src_enabled[`CCR_WK_VOLT_DET];

    wire next_wake =
        (|wake_grp_a) |
        (|wake_grp_b) |
        wake_wdog_a_rst |
        wake_reset_pin |
        wake_debug_on |
        wake_wdog_a_irq |
        wake_i2c |
        wake_wdog_b_rst |
        wake_wdog_b_irq |
        wake_comp_zero |
        wake_comp_one |
        wake_usb_resume |
        wake_volt_det;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= next_wake;
        end
    end

endmodule : ccr_chip_config
`default_nettype wire

// file: test/ccr_chip_config_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccr_defs.svh"
// ********
// bus and pin checks
// ********
module ccr_chip_config_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [3:0]  hprot,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [26:0] wake_sources,
    input wire logic        wake_request,
    input wire logic [31:0] drive_reduce_bits,
    input wire logic [31:0] slew_limit_bits,
    input wire logic [31:0] pulldown_enable_bits
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire        taken = hsel && hready && htrans[1];
    wire [95:0] pins  = {drive_reduce_bits, slew_limit_bits, pulldown_enable_bits};
    wire        id_rd   = taken && hprot[1] && !hwrite && haddr[7:0] == `CCR_OFF_IDTEST;
    wire        drv_wr  = taken && hprot[1] && hwrite && haddr[7:0] == `CCR_OFF_DRIVE;
    wire [15:0] id_half = {`CCR_PART_NUMBER, `CCR_MASK_REV};
    sequence s_err;
        !hreadyout && hresp ##1 hreadyout && hresp;
    endsequence
    a_user_err: assert property (taken && !hprot[1] |=> s_err)
        else $error("user access not refused");
    a_priv_okay: assert property (taken && hprot[1] |=> hreadyout && !hresp)
        else $error("privileged access not answered okay");
    a_user_nowrite: assert property (taken && !hprot[1] && hwrite |-> ##2 $stable(pins) ##1 $stable(pins))
        else $error("user write changed pins");
    a_user_rdzero: assert property (taken && !hprot[1] && !hwrite |=> hrdata == 32'h0)
        else $error("user read returned data");
    a_pin_mask: assert property ((pins & ~{3{`CCR_PIN_MASK}}) == 96'h0)
        else $error("reserved pin bit driven");
    a_wake_quiet: assert property (!(|wake_sources) [*8] |-> !wake_request)
        else $error("wake without source");
    a_id_read: assert property (id_rd |=> hrdata[31:16] == id_half)
        else $error("identification half wrong");
    a_drive_write: assert property (drv_wr |=> ##2 drive_reduce_bits == ($past(hwdata, 2) & `CCR_PIN_MASK))
        else $error("drive bits not written");
endmodule : ccr_chip_config_asserts
bind ccr_chip_config ccr_chip_config_asserts u_ccr_chip_config_asserts (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hprot                (hprot),
    .hready               (hready),
    .hwdata               (hwdata),
    .hrdata               (hrdata),
    .hreadyout            (hreadyout),
    .hresp                (hresp),
    .wake_sources         (wake_sources),
    .wake_request         (wake_request),
    .drive_reduce_bits    (drive_reduce_bits),
    .slew_limit_bits      (slew_limit_bits),
    .pulldown_enable_bits (pulldown_enable_bits)
);
`default_nettype wire

// file: test/ccr_chip_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ccr_defs.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
    $display("ERROR %s exp %h got %h", n, e, s); end end
// ********
// bench
// ********
module ccr_chip_config_tb;
    import ccr_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, wreq, er, seen;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, drv, slw, pdn, rd, d;
    logic [1:0]  htrans = 0;
    logic [3:0]  hprot = 4'h3;
    logic [26:0] wsrc = 0;
    logic [15:0] tctl;
    int          bad_count = 0, cmp_count = 0, cyc = 0;
    always #20 hclk = ~hclk;
    ccr_chip_config u_ccr_chip_config (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hprot(hprot), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wake_sources(wsrc),
        .wake_request(wreq), .drive_reduce_bits(drv), .slew_limit_bits(slw),
        .pulldown_enable_bits(pdn), .test_control(tctl));
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, input logic p);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= `CCR_HTRANS_NONSEQ;
        hwrite <= w;
        hprot <= {2'h0, p, 1'b1};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rd = hrdata;
        er = hresp;
    endtask : xfer
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 5000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 5; i++) begin
            xfer(8'(i * 4), 1'b0, 32'h0, 1'b1);
            `CHK("reset", (i == 4) ? {`CCR_PART_NUMBER, `CCR_MASK_REV, 16'h0} : 32'h0, rd)
        end
        for (int i = 0; i < 4; i++) xfer(8'(i * 4), 1'b1, 32'hF7F0F0F0 >> i, 1'b1);
        xfer(`CCR_OFF_IDTEST, 1'b1, 32'hFFFFBEEF, 1'b1);
        for (int i = 0; i < 4; i++) begin
            xfer(8'(i * 4), 1'b0, 32'h0, 1'b1);
            `CHK("readback", (i == 0) ? 32'h87F0F0F0 : 32'hF7F0F0F0 >> i, rd)
        end
        xfer(`CCR_OFF_IDTEST, 1'b0, 32'h0, 1'b1);
        `CHK("idtest", {`CCR_PART_NUMBER, `CCR_MASK_REV, 16'hBEEF}, rd)
        `CHK("test_control", 16'hBEEF, tctl)
        `CHK("drive", 32'h7BF87878 & `CCR_PIN_MASK, drv)
        `CHK("slew", 32'h3DFC3C3C & `CCR_PIN_MASK, slw)
        `CHK("pulldown", 32'h1EFE1E1E & `CCR_PIN_MASK, pdn)
        xfer(`CCR_OFF_DRIVE, 1'b1, 32'h0, 1'b0);
        `CHK("user write resp", 1'b1, er)
        xfer(`CCR_OFF_DRIVE, 1'b0, 32'h0, 1'b0);
        `CHK("user read", 33'h100000000, {er, rd})
        `CHK("drive kept", 32'h7BF87878 & `CCR_PIN_MASK, drv)
        xfer(8'h20, 1'b1, 32'hFFFFFFFF, 1'b1);
        xfer(8'h20, 1'b0, 32'h0, 1'b1);
        `CHK("unmapped", 33'h0, {er, rd})
        xfer(`CCR_OFF_IDTEST, 1'b1, 32'h0, 1'b1);
        for (int k = 0; k < 27; k++) begin
            d = 32'h1 << k;
            xfer(`CCR_OFF_WAKE, 1'b1, d, 1'b1);
            wsrc <= ~d[26:0];
            repeat (8) @(posedge hclk);
            `CHK("wake off", 1'b0, wreq)
            wsrc <= d[26:0];
            repeat (8) @(posedge hclk);
            `CHK("wake on", 1'b1, wreq)
            wsrc <= 27'h0;
            repeat (8) @(posedge hclk);
        end
        for (int f = 0; f < 2; f++) begin
            xfer(`CCR_OFF_WAKE, 1'b1, {f[0], 30'h0, 1'b1}, 1'b1);
            wsrc <= 27'h1;
            @(posedge hclk);
            wsrc <= 27'h0;
            seen = 1'b0;
            repeat (8) begin
                @(posedge hclk);
                seen = seen | wreq;
            end
            `CHK("glitch", !f[0], seen)
            wsrc <= 27'h1;
            repeat (8) @(posedge hclk);
            `CHK("filtered", 1'b1, wreq)
            wsrc <= 27'h0;
            repeat (8) @(posedge hclk);
        end
        complete_run();
    end
endmodule : ccr_chip_config_tb
`default_nettype wire
